/* clock_gen_pkg.sv */
// Constants shared by the master clock generation block.
package clock_gen_pkg;
  // Clock source select field codes.
  localparam logic [1:0] SRC_BYPASS_MSB = 2'h0;
  localparam logic [1:0] SRC_PLL        = 2'h3;
  // Field widths and limits.
  localparam int          IDIV_W        = 2;
  localparam int          ODIV_W        = 4;
  localparam int          MUL_W         = 5;
  localparam int          DIV_W         = 7;
  localparam logic [1:0]  IDIV_MAX      = 2'h3;
  localparam logic [3:0]  ODIV_MAX      = 4'hE;
  // VCO band codes.
  localparam logic [1:0]  VB_LOW        = 2'h0;
  localparam logic [1:0]  VB_MID        = 2'h1;
  localparam logic [1:0]  VB_HIGH       = 2'h2;
  localparam logic [1:0]  VB_RESERVED   = 2'h3;
  // Oscillator model: phase accumulator width and band limits of its step.
  localparam int          NCO_W         = 16;
  localparam logic [15:0] BAND0_MIN     = 16'h0800;
  localparam logic [15:0] BAND0_MAX     = 16'h1800;
  localparam logic [15:0] BAND1_MIN     = 16'h1800;
  localparam logic [15:0] BAND1_MAX     = 16'h2800;
  localparam logic [15:0] BAND2_MIN     = 16'h2800;
  localparam logic [15:0] BAND2_MAX     = 16'h3800;
  localparam logic [15:0] NCO_STEP      = 16'h0080;
  // Edge counter width of one reference period.
  localparam int          CNT_W         = 8;
  localparam logic [7:0]  CNT_SAT       = 8'hFF;
  // CPU clock divisor values.
  localparam logic [1:0]  CPU_DIV_ONE   = 2'h1;
  localparam logic [1:0]  CPU_DIV_TWO   = 2'h2;
endpackage

/* edge_divider.sv */
// Divides a stream of edge events, toggling its output every div events.
`timescale 1ns/1ps
`default_nettype none
module edge_divider #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Events and divisor
  input  wire logic         tick,
  input  wire logic [W-1:0] div,
  // Divided level
  output var  logic         level_ff
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         wrap;

  assign wrap    = (cnt_ff + W'(1)) >= div;
  assign nxt_cnt = wrap ? '0 : cnt_ff + W'(1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= '0;
      level_ff <= 1'b0;
    end else if (tick) begin
      cnt_ff   <= nxt_cnt;
      level_ff <= wrap ? ~level_ff : level_ff;
    end
  end
endmodule
`default_nettype wire

/* master_clock_gen.sv */
// Master, CPU and system clock generation from the oscillator input.
//
// Function
// - Source mode chosen by software configuration.
// - Bypass divides oscillator by both prescaler products.
// - Input prescale max 3, output max 14.
// - Zero prescales in bypass make master follow oscillator.
// - Locked-loop code enables loop, sources master.
// - Loop mode scales by multiplier over prescalers.
// - Output prescaler divides VCO into master.
// - Loop pulls into lock gradually, no jumps.
// - VCO band selects three bands; 11 reserved.
// - CPU clock is master or half, one bit.
// - CPU and bus controller use CPU clock.
// - System clock runs at CPU clock frequency.
`timescale 1ns/1ps
`default_nettype none
module master_clock_gen #(
  parameter int MUL_W = clock_gen_pkg::MUL_W
) (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             arst_n,
  // Oscillator
  input  wire logic                             oscillator_input,
  // Clock generation configuration
  input  wire logic [1:0]                       clock_source_select,
  input  wire logic [clock_gen_pkg::IDIV_W-1:0] input_prescale,
  input  wire logic [clock_gen_pkg::ODIV_W-1:0] output_prescale,
  input  wire logic [MUL_W-1:0]                 feedback_multiplier,
  input  wire logic [1:0]                       vco_band,
  // System configuration
  input  wire logic                             cpu_clock_halve,
  // Generated clocks
  output var  logic                             master_clk_ff,
  output var  logic                             cpu_clk_ff,
  output var  logic                             ebc_clk_ff,
  output var  logic                             sys_clk_ff,
  // Status
  output var  logic                             pll_enable_ff,
  output var  logic                             pll_locked_ff
);
  typedef enum logic [1:0] {
    PLL_OFF     = 2'b00,
    PLL_ACQUIRE = 2'b01,
    PLL_LOCKED  = 2'b10
  } pll_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic rst_meta_ff;
  logic rst_n;
  logic rst_sync_ff;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode.
  logic                             pll_mode;
  logic [clock_gen_pkg::ODIV_W-1:0] odiv_lim;
  logic [clock_gen_pkg::DIV_W-1:0]  idiv_fac;
  logic [clock_gen_pkg::DIV_W-1:0]  odiv_fac;
  logic [clock_gen_pkg::DIV_W-1:0]  bypass_div;
  logic [clock_gen_pkg::CNT_W-1:0]  edge_target;

  assign pll_mode    = clock_source_select == clock_gen_pkg::SRC_PLL;
  assign odiv_lim    = (output_prescale > clock_gen_pkg::ODIV_MAX) ?
                       clock_gen_pkg::ODIV_MAX : output_prescale;
  assign idiv_fac    = clock_gen_pkg::DIV_W'(input_prescale) + 7'h01;
  assign odiv_fac    = clock_gen_pkg::DIV_W'(odiv_lim) + 7'h01;
  assign bypass_div  = clock_gen_pkg::DIV_W'(idiv_fac * odiv_fac);
  // Two VCO edges make one VCO period.
  assign edge_target = clock_gen_pkg::CNT_W'({feedback_multiplier, 1'b0}) + 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator edge detection and reference divider.
  logic                            osc_ff;
  logic                            osc_prev_ff;
  logic                            osc_edge;
  logic                            osc_rise;
  logic [clock_gen_pkg::DIV_W-1:0] ref_cnt_ff;
  logic                            ref_tick;

  assign osc_edge = osc_ff ^ osc_prev_ff;
  assign osc_rise = osc_ff & ~osc_prev_ff;
  assign ref_tick = osc_rise && ((ref_cnt_ff + 7'h01) >= idiv_fac);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_ff      <= 1'b0;
      osc_prev_ff <= 1'b0;
      ref_cnt_ff  <= '0;
    end else begin
      osc_ff      <= oscillator_input;
      osc_prev_ff <= osc_ff;
      if (osc_rise) begin
        ref_cnt_ff <= ref_tick ? '0 : ref_cnt_ff + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // VCO band limits; the reserved code keeps the last valid band.
  logic [1:0]                      band_ff;
  logic [clock_gen_pkg::NCO_W-1:0] band_min;
  logic [clock_gen_pkg::NCO_W-1:0] band_max;

  assign band_min = (band_ff == clock_gen_pkg::VB_MID)  ? clock_gen_pkg::BAND1_MIN :
                    (band_ff == clock_gen_pkg::VB_HIGH) ? clock_gen_pkg::BAND2_MIN :
                    clock_gen_pkg::BAND0_MIN;
  assign band_max = (band_ff == clock_gen_pkg::VB_MID)  ? clock_gen_pkg::BAND1_MAX :
                    (band_ff == clock_gen_pkg::VB_HIGH) ? clock_gen_pkg::BAND2_MAX :
                    clock_gen_pkg::BAND0_MAX;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      band_ff <= clock_gen_pkg::VB_LOW;
    end else if (vco_band != clock_gen_pkg::VB_RESERVED) begin
      band_ff <= vco_band;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Locked loop: a phase accumulator whose step moves by one unit per
  // reference period inside the band, and by one unit per cycle back into
  // the band when outside it, so the VCO frequency only ever slews.
  pll_state_e                      state_ff;
  pll_state_e                      nxt_state;
  logic [clock_gen_pkg::NCO_W-1:0] phase_ff;
  logic [clock_gen_pkg::NCO_W-1:0] step_ff;
  logic [clock_gen_pkg::NCO_W-1:0] nxt_step;
  logic [clock_gen_pkg::NCO_W:0]   phase_sum;
  logic                            vco_edge;
  logic [clock_gen_pkg::CNT_W-1:0] vco_cnt_ff;
  logic                            too_slow;
  logic                            too_fast;

  assign phase_sum = {1'b0, phase_ff} + {1'b0, step_ff};
  assign vco_edge  = (state_ff != PLL_OFF) && phase_sum[clock_gen_pkg::NCO_W];
  assign too_slow  = vco_cnt_ff < edge_target;
  assign too_fast  = vco_cnt_ff > edge_target;

  always_comb begin
    nxt_step = step_ff;
    if (step_ff < band_min) begin
      nxt_step = step_ff + clock_gen_pkg::NCO_STEP;
    end else if (step_ff > band_max) begin
      nxt_step = step_ff - clock_gen_pkg::NCO_STEP;
    end else if (ref_tick && too_slow && step_ff < band_max) begin
      nxt_step = step_ff + clock_gen_pkg::NCO_STEP;
    end else if (ref_tick && too_fast && step_ff > band_min) begin
      nxt_step = step_ff - clock_gen_pkg::NCO_STEP;
    end
  end

  always_comb begin
    case (state_ff)
      PLL_OFF:     nxt_state = pll_mode ? PLL_ACQUIRE : PLL_OFF;
      PLL_ACQUIRE: nxt_state = !pll_mode ? PLL_OFF :
                               (ref_tick && !too_slow && !too_fast) ? PLL_LOCKED :
                               PLL_ACQUIRE;
      PLL_LOCKED:  nxt_state = !pll_mode ? PLL_OFF :
                               (ref_tick && (too_slow || too_fast)) ? PLL_ACQUIRE :
                               PLL_LOCKED;
      default:     nxt_state = PLL_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= PLL_OFF;
      phase_ff   <= '0;
      step_ff    <= clock_gen_pkg::BAND0_MIN;
      vco_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == PLL_OFF) begin
        phase_ff   <= '0;
        step_ff    <= band_min;
        vco_cnt_ff <= '0;
      end else begin
        phase_ff <= phase_sum[clock_gen_pkg::NCO_W-1:0];
        step_ff  <= nxt_step;
        if (ref_tick) begin
          vco_cnt_ff <= vco_edge ? 8'h01 : '0;
        end else if (vco_edge && vco_cnt_ff != clock_gen_pkg::CNT_SAT) begin
          vco_cnt_ff <= vco_cnt_ff + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock: bypass divides oscillator edges, loop mode divides VCO
  // edges by the output prescaler.
  logic                            mc_tick;
  logic [clock_gen_pkg::DIV_W-1:0] mc_div;
  logic                            mc_level;

  assign mc_tick = pll_mode ? vco_edge : osc_edge;
  assign mc_div  = pll_mode ? odiv_fac : bypass_div;

  edge_divider #(.W(clock_gen_pkg::DIV_W)) u_master_div (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick     (mc_tick),
    .div      (mc_div),
    .level_ff (mc_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock: master clock edges divided by one or two.
  logic       mc_prev_ff;
  logic       mc_edge;
  logic [1:0] cpu_div;
  logic       cpu_level;

  assign mc_edge = mc_level ^ mc_prev_ff;
  assign cpu_div = cpu_clock_halve ? clock_gen_pkg::CPU_DIV_TWO :
                   clock_gen_pkg::CPU_DIV_ONE;

  edge_divider #(.W(2)) u_cpu_div (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick     (mc_edge),
    .div      (cpu_div),
    .level_ff (cpu_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mc_prev_ff    <= 1'b0;
      master_clk_ff <= 1'b0;
      cpu_clk_ff    <= 1'b0;
      ebc_clk_ff    <= 1'b0;
      sys_clk_ff    <= 1'b0;
      pll_enable_ff <= 1'b0;
      pll_locked_ff <= 1'b0;
    end else begin
      mc_prev_ff    <= mc_level;
      master_clk_ff <= mc_level;
      cpu_clk_ff    <= cpu_level;
      ebc_clk_ff    <= cpu_level;
      sys_clk_ff    <= cpu_level;
      pll_enable_ff <= state_ff != PLL_OFF;
      pll_locked_ff <= state_ff == PLL_LOCKED;
    end
  end
endmodule
`default_nettype wire

/* osc_source.sv */
// Free-running oscillator model with programmable high and low times.
`timescale 1ns/1ps
`default_nettype none
module osc_source (
  // Clock and half-period lengths in mclk cycles
  input  wire logic       mclk,
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  // Oscillator level
  output wire logic       osc_level
);
  logic       lvl = 1'b0;
  logic [7:0] cnt = 8'h00;
  assign osc_level = lvl;
  always @(posedge mclk) begin
    #2;
    if (cnt + 8'h01 >= (lvl ? hi_len : lo_len)) begin
      lvl = !lvl;
      cnt = 8'h00;
    end else begin
      cnt = cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* master_clock_gen_checker.sv */
// Assertions on the ports of the master clock generation block.
`timescale 1ns/1ps
`default_nettype none
module master_clock_gen_checker #(
  parameter int MUL_W = clock_gen_pkg::MUL_W
) (
  // Clock, reset and oscillator
  input wire logic             mclk,
  input wire logic             arst_n,
  input wire logic             oscillator_input,
  // Configuration
  input wire logic [1:0]       clock_source_select,
  input wire logic [1:0]       input_prescale,
  input wire logic [3:0]       output_prescale,
  input wire logic [MUL_W-1:0] feedback_multiplier,
  input wire logic [1:0]       vco_band,
  input wire logic             cpu_clock_halve,
  // Clocks and status
  input wire logic             master_clk_ff,
  input wire logic             cpu_clk_ff,
  input wire logic             ebc_clk_ff,
  input wire logic             sys_clk_ff,
  input wire logic             pll_enable_ff,
  input wire logic             pll_locked_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic       osc_q_ff, mst_q_ff, cpu_q_ff, hlv_q_ff;
  logic [3:0] age_ff;
  logic [2:0] mcnt_ff;
  logic [1:0] hold_ff;
  wire logic  mst_chg = mst_q_ff != master_clk_ff;
  wire logic  cpu_chg = cpu_q_ff != cpu_clk_ff;
  wire logic  is_pll = clock_source_select == clock_gen_pkg::SRC_PLL;
  // The halving bit must have stood still since the last counted CPU edges.
  wire logic  hlv_ok = hold_ff == 2'h3 && hlv_q_ff == cpu_clock_halve;
  // Counts master toggles per CPU toggle, once the halving bit has settled.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {osc_q_ff, mst_q_ff, cpu_q_ff, hlv_q_ff} <= 4'h0;
      {age_ff, mcnt_ff, hold_ff} <= 9'h000;
    end else begin
      {osc_q_ff, mst_q_ff, cpu_q_ff} <= {oscillator_input, master_clk_ff, cpu_clk_ff};
      hlv_q_ff <= cpu_clock_halve;
      age_ff <= (osc_q_ff != oscillator_input) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hF};
      mcnt_ff <= cpu_chg ? 3'h0 : mcnt_ff + {2'h0, mst_chg && mcnt_ff != 3'h7};
      hold_ff <= (hlv_q_ff != cpu_clock_halve) ? 2'h0 : hold_ff + {1'h0, cpu_chg && hold_ff != 2'h3};
    end
  end
  ebc_eq_cpu_a: assert property (ebc_clk_ff == cpu_clk_ff) else $error("ebc clock differs");
  sys_eq_cpu_a: assert property (sys_clk_ff == cpu_clk_ff) else $error("sys clock differs");
  pll_on_a: assert property (is_pll [*6] |-> pll_enable_ff) else $error("loop not enabled");
  pll_off_a: assert property (!is_pll [*6] |-> !pll_enable_ff) else $error("loop not off");
  lock_off_a: assert property (!is_pll [*6] |-> !pll_locked_ff) else $error("lock in bypass");
  master_src_a: assert property (!is_pll [*8] ##1 mst_chg |-> age_ff <= 4'h6)
    else $error("bypass master moved without oscillator edge");
  cpu_ratio_a: assert property (hlv_ok && cpu_chg |->
    mcnt_ff + {2'h0, mst_chg} == (cpu_clock_halve ? 3'h2 : 3'h1)) else $error("cpu ratio wrong");
  cpu_bound_a: assert property (hlv_ok |-> mcnt_ff <= (cpu_clock_halve ? 3'h2 : 3'h1))
    else $error("cpu clock stalled");
endmodule
bind master_clock_gen master_clock_gen_checker #(.MUL_W(MUL_W)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .oscillator_input(oscillator_input),
  .clock_source_select(clock_source_select), .input_prescale(input_prescale),
  .output_prescale(output_prescale), .feedback_multiplier(feedback_multiplier),
  .vco_band(vco_band), .cpu_clock_halve(cpu_clock_halve), .master_clk_ff(master_clk_ff),
  .cpu_clk_ff(cpu_clk_ff), .ebc_clk_ff(ebc_clk_ff), .sys_clk_ff(sys_clk_ff),
  .pll_enable_ff(pll_enable_ff), .pll_locked_ff(pll_locked_ff));
`default_nettype wire

/* master_clock_gen_bench.sv */
// Self-checking bench for the master clock generation block.
`timescale 1ns/1ps
`default_nettype none
module master_clock_gen_bench;
  logic       mclk, arst_n, halve;
  logic [1:0] sel, ip, vb;
  logic [3:0] op;
  logic [4:0] mul;
  logic [7:0] hi_len, lo_len;
  wire logic  osc, mst, cpu, pll_en, pll_lk;
  int         error_cnt, num_checks, cyc, c, h;
  int         n_tab [4] = '{1, 6, 60, 45};
  logic [1:0] s_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [1:0] i_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [3:0] o_tab [4] = '{4'h0, 4'h2, 4'hE, 4'hF};
  // Each multiplier fits its band; the last lock needs the reserved code to keep band two.
  logic [4:0] m_tab [4] = '{5'h00, 5'h01, 5'h02, 5'h02};
  master_clock_gen u_master_clock_gen (.mclk(mclk), .arst_n(arst_n), .oscillator_input(osc),
    .clock_source_select(sel), .input_prescale(ip), .output_prescale(op),
    .feedback_multiplier(mul), .vco_band(vb), .cpu_clock_halve(halve), .master_clk_ff(mst),
    .cpu_clk_ff(cpu), .ebc_clk_ff(), .sys_clk_ff(), .pll_enable_ff(pll_en),
    .pll_locked_ff(pll_lk));
  osc_source u_osc_source (.mclk(mclk), .hi_len(hi_len), .lo_len(lo_len), .osc_level(osc));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      $display("ERROR timeout expected 0 seen %0d", cyc);
      tally_and_finish;
    end
  end
  task automatic chk(input string what, input int exp, input logic [31:0] got, input int tol);
    num_checks++;
    if (^got === 1'bx || int'(got) > exp + tol || int'(got) < exp - tol) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? mst : cpu;
  endfunction
  // Counts cycles over n rising-edge periods, and high cycles of the first one.
  task automatic span(input int w, input int n, output int cc, output int hh);
    int   r, t;
    logic p;
    {r, t, cc, hh} = '0;
    p = pick(w);
    while (r <= n && t < 6000) begin
      @(posedge mclk);
      #1;
      t++;
      if (r > 0) cc++;
      if (pick(w) === 1'b1 && p === 1'b0) r++;
      if (r == 1 && pick(w) === 1'b1) hh++;
      p = pick(w);
    end
  endtask
  task automatic cfg(input logic [1:0] s, i, input logic [3:0] o, input logic [4:0] m,
                     input logic [1:0] v, input logic hv);
    @(posedge mclk);
    #1;
    {sel, ip, op, mul, vb, halve} = {s, i, o, m, v, hv};
  endtask
  initial begin
    {arst_n, sel, ip, op, mul, vb, halve} = '0;
    {hi_len, lo_len} = {8'h03, 8'h05};
    {error_cnt, num_checks, cyc} = '0;
    repeat (5) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      cfg(s_tab[k], i_tab[k], o_tab[k], 5'h00, 2'h0, 1'b0);
      span(0, 1, c, h);
      span(0, 2, c, h);
      chk("master_period", 16 * n_tab[k], c, 0);
      if (k == 0) chk("master_high", 3, h, 0);
    end
    $display("test bypass done");
    for (int k = 0; k < 2; k++) begin
      cfg(2'h0, 2'h0, 4'h0, 5'h00, 2'h0, 1'(k));
      span(1, 2, c, h);
      span(1, 2, c, h);
      chk("cpu_period", 16 * (k + 1), c, 0);
    end
    $display("test cpu done");
    {hi_len, lo_len} = {8'h10, 8'h10};
    for (int k = 0; k < 4; k++) begin
      cfg(2'h0, 2'h0, 4'h1, m_tab[k], 2'(k), 1'b0);
      repeat (3) @(posedge mclk);
      #1;
      chk("pll_enable", 0, {31'h0, pll_en}, 0);
      cfg(2'h3, 2'h0, 4'h1, m_tab[k], 2'(k), 1'b0);
      repeat (3) @(posedge mclk);
      #1;
      chk("pll_enable", 1, {31'h0, pll_en}, 0);
      // Early windows can match by phase alone, so let the loop settle first.
      repeat (6000) @(posedge mclk);
      #1;
      chk("pll_locked", 1, {31'h0, pll_lk}, 0);
      span(0, 1, c, h);
      span(0, 4, c, h);
      chk("pll_period", 256 / (m_tab[k] + 1), c, 6);
    end
    cfg(2'h0, 2'h0, 4'h0, 5'h00, 2'h0, 1'b0);
    repeat (10) @(posedge mclk);
    #1;
    chk("pll_enable", 0, {31'h0, pll_en}, 0);
    $display("test loop done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
